// *** pkg/eeprom_port_defs.svh ***
// Behaviour
// - A 512-byte data EEPROM array, separate from program and data memory.
// - Each single byte can be read or written on its own.
// - Address, data and control registers sit in the I/O register space.
// - Writes are self-timed; a busy bit shows when the next byte may go.
// - A triggered read stalls the CPU for four clock cycles.
// - A triggered write stalls the CPU for two clock cycles.
// - A write is accepted only through the guarded two-step procedure.
// - The byte address is a 9-bit field, bits 8 to 0 of the pair.
// - Address bits 15 to 9 are reserved and read as zero.
// - Bytes are addressed linearly from zero to the last location.
// - Reset leaves the address register undefined.
// - A write programs the data register byte at the held address.
// - A read loads the byte at the held address into the data register.
// - Write starts only within four cycles of master enable, then it clears.
// - Hardware clears the write strobe when the write time has elapsed.
// - Setting the read strobe reads at once; data is there immediately.
// - During a write, no read and no address change.
`ifndef EEPROM_PORT_DEFS_SVH
`define EEPROM_PORT_DEFS_SVH

// ****************************************
// I/O register offsets
// ****************************************
`define IO_ADDR_W        6
`define OFS_DATA_BYTE    6'h00
`define OFS_ADDR_LOW     6'h01
`define OFS_ADDR_HIGH    6'h02
`define OFS_CONTROL      6'h03

// ****************************************
// Control field positions
// ****************************************
`define CTL_READ_BIT     0
`define CTL_WRITE_BIT    1
`define CTL_MASTER_BIT   2

// ****************************************
// Sizes, reset values, timing
// ****************************************
`define NV_DEPTH         512
`define NV_ADDR_W        9
`define DATA_RESET       8'h00
`define MASTER_WIN_CYC   3'h4
`define READ_STALL_CYC   3'h4
`define WRITE_STALL_CYC  3'h2
`define CLK_PERIOD_NS    4
`define PROG_TIME_NS     3400000
`define PROG_CYCLES      (`PROG_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** pkg/eeprom_port_pkg.sv ***
package eeprom_port_pkg;
   typedef enum logic [0:0] {
      WR_IDLE = 1'b0,
      WR_BUSY = 1'b1
   } wr_state_e;
   typedef logic [7:0] byte_t;
endpackage

// *** rtl/nv_byte_array.sv ***
`timescale 1ns/100ps
`default_nettype none
module nv_byte_array #(
   parameter int DEPTH  = 512,
   parameter int ADDR_W = 9
) (
   // Clock
   input  wire logic              clk,
   // Write port
   input  wire logic              wrEn,
   input  wire logic [ADDR_W-1:0] wrAddr,
   input  wire logic [7:0]        wrData,
   // Read port
   input  wire logic [ADDR_W-1:0] rdAddr,
   output logic      [7:0]        rdData
);
   // ****************************************
   // Storage
   // ****************************************
   // Not reset: contents model nonvolatile cells
   logic [7:0] cells_r [DEPTH];

   generate
      if (DEPTH != (1 << ADDR_W)) begin : g_bad
         $error("Depth must equal two to the address width");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (wrEn) begin
         cells_r[wrAddr] <= wrData;
      end
   end

   // Linear index, no remapping
   assign rdData = cells_r[rdAddr];
endmodule
`default_nettype wire

// *** rtl/eeprom_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_port_defs.svh"
module eeprom_port
   import eeprom_port_pkg::*;
#(
   parameter int DEPTH       = `NV_DEPTH,
   parameter int ADDR_W      = `NV_ADDR_W,
   parameter int PROG_CYCLES = `PROG_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // I/O register port
   input  wire logic [`IO_ADDR_W-1:0] ioAddr,
   input  wire logic                 ioWrite,
   input  wire logic                 ioRead,
   input  wire logic [7:0]           ioWdata,
   output logic      [7:0]           ioRdata,
   // CPU halt
   output logic                      cpuStall
);
   // ****************************************
   // Decode
   // ****************************************
   function automatic logic hit(input logic [`IO_ADDR_W-1:0] a,
                                input logic [`IO_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   logic            ctrlWr;
   logic            dataWr;
   logic            lowWr;
   logic            highWr;
   logic            readGo;
   logic            writeGo;
   logic            commit;
   logic [7:0]      arrayRd;
   logic [ADDR_W-1:0] addr_r;
   byte_t           data_r;
   byte_t           progData_r;
   logic            masterEn_r;
   logic [2:0]      meCnt_r;
   logic [2:0]      stallCnt_r;
   logic [31:0]     progCnt_r;
   wr_state_e       wrState_r;
   logic            busy;

   generate
      if (PROG_CYCLES < 1 || ADDR_W != 9 || DEPTH != (1 << ADDR_W))
      begin : g_bad
         $error("Unsupported eeprom port parameters");
      end
   endgenerate

   // Registers live in the I/O space
   always_comb begin
      ctrlWr = 1'b0;
      dataWr = 1'b0;
      lowWr  = 1'b0;
      highWr = 1'b0;
      if (!ioWrite) begin
         ctrlWr = 1'b0;
      end else if (hit(ioAddr, `OFS_CONTROL)) begin
         ctrlWr = 1'b1;
      end else if (hit(ioAddr, `OFS_DATA_BYTE)) begin
         dataWr = 1'b1;
      end else if (hit(ioAddr, `OFS_ADDR_LOW)) begin
         lowWr = 1'b1;
      end else if (hit(ioAddr, `OFS_ADDR_HIGH)) begin
         highWr = 1'b1;
      end
   end

   assign busy = (wrState_r == WR_BUSY);
   // Write wins over read when both strobes arrive together
   assign writeGo = ctrlWr && ioWdata[`CTL_WRITE_BIT] && masterEn_r
                    && !busy;
   assign readGo  = ctrlWr && ioWdata[`CTL_READ_BIT] && !busy
                    && !writeGo;
   assign commit  = busy && (progCnt_r == 32'h0000_0001);

   // ****************************************
   // Address register
   // ****************************************
   // No reset on purpose: contents undefined until software loads it
   always_ff @(posedge clk) begin
      if (lowWr && !busy) begin
         addr_r[7:0] <= ioWdata;
      end
      if (highWr && !busy) begin
         addr_r[8] <= ioWdata[0];
      end
   end

   // ****************************************
   // Data register
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         data_r <= `DATA_RESET;
      end else if (readGo) begin
         data_r <= arrayRd;
      end else if (dataWr) begin
         data_r <= ioWdata;
      end
   end

   // ****************************************
   // Master enable window
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         masterEn_r <= 1'b0;
         meCnt_r    <= 3'h0;
      end else if (ctrlWr && ioWdata[`CTL_MASTER_BIT]
                   && !ioWdata[`CTL_WRITE_BIT]) begin
         masterEn_r <= 1'b1;
         meCnt_r    <= `MASTER_WIN_CYC - 3'h1;
      end else if (masterEn_r) begin
         if (meCnt_r == 3'h0 || writeGo) begin
            masterEn_r <= 1'b0;
         end
         meCnt_r <= meCnt_r - 3'h1;
      end
   end

   // ****************************************
   // Self-timed write
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wrState_r  <= WR_IDLE;
         progCnt_r  <= 32'h0000_0000;
         progData_r <= `DATA_RESET;
      end else begin
         case (wrState_r)
            WR_IDLE: begin
               if (writeGo) begin
                  wrState_r  <= WR_BUSY;
                  progCnt_r  <= 32'(PROG_CYCLES);
                  progData_r <= data_r;
               end
            end
            WR_BUSY: begin
               progCnt_r <= progCnt_r - 32'h0000_0001;
               if (commit) begin
                  wrState_r <= WR_IDLE;
               end
            end
            default: wrState_r <= WR_IDLE;
         endcase
      end
   end

   // Array written only at the end of the timed write
   nv_byte_array #(
      .DEPTH  (DEPTH),
      .ADDR_W (ADDR_W)
   ) u_array (
      .clk    (clk),
      .wrEn   (commit),
      .wrAddr (addr_r),
      .wrData (progData_r),
      .rdAddr (addr_r),
      .rdData (arrayRd)
   );

   // ****************************************
   // CPU stall
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stallCnt_r <= 3'h0;
      end else if (readGo) begin
         stallCnt_r <= `READ_STALL_CYC;
      end else if (writeGo) begin
         stallCnt_r <= `WRITE_STALL_CYC;
      end else if (stallCnt_r != 3'h0) begin
         stallCnt_r <= stallCnt_r - 3'h1;
      end
   end

   assign cpuStall = (stallCnt_r != 3'h0);

   // ****************************************
   // Read-back
   // ****************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ioRdata <= 8'h00;
      end else if (ioRead) begin
         if (hit(ioAddr, `OFS_DATA_BYTE)) begin
            ioRdata <= data_r;
         end else if (hit(ioAddr, `OFS_ADDR_LOW)) begin
            ioRdata <= addr_r[7:0];
         end else if (hit(ioAddr, `OFS_ADDR_HIGH)) begin
            ioRdata <= {7'h00, addr_r[8]};
         end else if (hit(ioAddr, `OFS_CONTROL)) begin
            ioRdata <= {5'h00, masterEn_r, busy, 1'b0};
         end else begin
            ioRdata <= 8'h00;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   read_stall_a: assert property (
      readGo |=> cpuStall [*4] ##1 !cpuStall)
      else $error("read stall length wrong");

   write_stall_a: assert property (
      writeGo |=> cpuStall [*2] ##1 !cpuStall)
      else $error("write stall length wrong");

   guard_write_a: assert property (
      (ctrlWr && ioWdata[1] && !masterEn_r && !busy) |=> !busy)
      else $error("write started without master enable");

   // A write start ends the window early, so only an unused window is timed
   master_window_a: assert property (
      (ctrlWr && ioWdata[2] && !ioWdata[1])
      ##1 (!writeGo && !(ctrlWr && ioWdata[2])) [*4]
      |-> masterEn_r ##1 !masterEn_r)
      else $error("master enable window wrong");

   master_clear_a: assert property (
      writeGo |=> !masterEn_r)
      else $error("master enable kept after write start");

   strobe_clear_a: assert property (
      commit |=> !busy)
      else $error("write strobe not cleared");

   // A read in the commit cycle still sees busy; the next one must not
   strobe_read_a: assert property (
      (commit ##1 (ioRead && ioAddr == `OFS_CONTROL))
      |=> !ioRdata[1])
      else $error("busy bit read back after write end");

   addr_lock_a: assert property (
      busy |=> $stable(addr_r))
      else $error("address changed during write");

   read_data_a: assert property (
      readGo |=> data_r == $past(arrayRd))
      else $error("read data not loaded");

   reserved_zero_a: assert property (
      (ioRead && ioAddr == `OFS_ADDR_HIGH) |=> ioRdata[7:1] == 7'h00)
      else $error("reserved address bits not zero");

   write_commit_a: assert property (
      writeGo |=> busy ##0 progData_r == $past(data_r))
      else $error("write data not captured");
endmodule
`default_nettype wire

// *** bench/cpu_io_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_port_defs.svh"
module cpu_io_model
   import eeprom_port_pkg::*;
(
   // Clock and halt
   input  wire logic                  clk,
   input  wire logic                  cpuStall,
   // I/O register port
   output logic [`IO_ADDR_W-1:0]      ioAddr,
   output logic                       ioWrite,
   output logic                       ioRead,
   output logic [7:0]                 ioWdata,
   input  wire logic [7:0]            ioRdata
);
   initial begin
      ioAddr = '0;
      ioWrite = 1'b0;
      ioRead = 1'b0;
      ioWdata = 8'h00;
   end
   // Core issues nothing while halted; extra edge lets the halt appear
   task automatic idle_wait();
      int n;
      n = 0;
      @(negedge clk);
      while (cpuStall !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic wr(input logic [`IO_ADDR_W-1:0] ofs, input byte_t d);
      idle_wait();
      ioAddr = ofs;
      ioWdata = d;
      ioWrite = 1'b1;
      @(negedge clk);
      ioWrite = 1'b0;
      ioWdata = ~d; // Released bus never keeps the old value
   endtask
   task automatic rd(input logic [`IO_ADDR_W-1:0] ofs, output byte_t d);
      idle_wait();
      ioAddr = ofs;
      ioRead = 1'b1;
      @(negedge clk);
      ioRead = 1'b0;
      @(negedge clk);
      d = ioRdata;
   endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_port_defs.svh"
module tb
   import eeprom_port_pkg::*;
;
   localparam int PROG = 20; // Short timed write keeps the run brief
   logic                  clk = 1'b0;
   logic                  resetN = 1'b0;
   logic [`IO_ADDR_W-1:0] ioAddr;
   logic                  ioWrite;
   logic                  ioRead;
   byte_t                 ioWdata;
   byte_t                 ioRdata;
   logic                  cpuStall;
   int                    errors = 0;
   int                    cmpCount = 0;
   int                    stallCnt = 0;
   int                    cycles = 0;
   logic [8:0]            addrs [3] = '{9'h000, 9'h1FF, 9'h0FF};
   byte_t                 dats [3] = '{8'h5A, 8'hC3, 8'h17};

   always #2 clk = ~clk;
   // Sampled off the launching edge so the halt is settled
   always @(negedge clk) begin
      if (cpuStall === 1'b1) stallCnt++;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end

   eeprom_port #(.PROG_CYCLES(PROG)) i_dut (
      .clk(clk), .reset_n(resetN), .ioAddr(ioAddr), .ioWrite(ioWrite),
      .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata),
      .cpuStall(cpuStall));
   cpu_io_model i_cpu (
      .clk(clk), .cpuStall(cpuStall), .ioAddr(ioAddr), .ioWrite(ioWrite),
      .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input byte_t seen, input byte_t exp);
      cmpCount++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [`IO_ADDR_W-1:0] ofs, input byte_t exp);
      byte_t d;
      i_cpu.rd(ofs, d);
      check(d, exp);
   endtask
   // Junk in the upper bits must be dropped by the port
   task automatic set_addr(input logic [8:0] a);
      i_cpu.wr(`OFS_ADDR_LOW, a[7:0]);
      i_cpu.wr(`OFS_ADDR_HIGH, {7'h7F, a[8]});
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      int    s0;
      int    n;
      byte_t c;
      repeat (6) @(negedge clk);
      resetN = 1'b1;
      rd_chk(`OFS_DATA_BYTE, 8'h00);
      rd_chk(`OFS_CONTROL, 8'h00);
      rd_chk(6'h3F, 8'h00);
      set_addr(9'h1A5);
      rd_chk(`OFS_ADDR_HIGH, 8'h01);
      rd_chk(`OFS_ADDR_LOW, 8'hA5);
      for (int i = 0; i < 3; i++) begin
         set_addr(addrs[i]);
         i_cpu.wr(`OFS_DATA_BYTE, dats[i]);
         s0 = stallCnt;
         i_cpu.wr(`OFS_CONTROL, 8'h04);
         i_cpu.wr(`OFS_CONTROL, 8'h02);
         rd_chk(`OFS_CONTROL, 8'h02);
         check(byte_t'(stallCnt - s0), 8'h02);
         i_cpu.wr(`OFS_ADDR_LOW, ~addrs[i][7:0]);
         n = 0;
         c = 8'hFF;
         while (c !== 8'h00 && n < 40) begin
            i_cpu.rd(`OFS_CONTROL, c);
            n++;
         end
         check(c, 8'h00);
         rd_chk(`OFS_ADDR_LOW, addrs[i][7:0]);
      end
      // Unguarded, combined and late strobes must all be refused
      set_addr(9'h000);
      i_cpu.wr(`OFS_DATA_BYTE, 8'hEE);
      i_cpu.wr(`OFS_CONTROL, 8'h02);
      i_cpu.wr(`OFS_CONTROL, 8'h06);
      i_cpu.wr(`OFS_CONTROL, 8'h02);
      i_cpu.wr(`OFS_CONTROL, 8'h04);
      rd_chk(`OFS_CONTROL, 8'h04);
      repeat (4) @(negedge clk);
      i_cpu.wr(`OFS_CONTROL, 8'h02);
      rd_chk(`OFS_CONTROL, 8'h00);
      for (int i = 0; i < 3; i++) begin
         set_addr(addrs[i]);
         s0 = stallCnt;
         i_cpu.wr(`OFS_CONTROL, 8'h01);
         rd_chk(`OFS_DATA_BYTE, dats[i]);
         check(byte_t'(stallCnt - s0), 8'h04);
      end
      final_report();
   end
endmodule
`default_nettype wire
